// ### design/charger_option_registers.sv
// Charger option registers with limit select, discharge enable and adapter-ok deglitch
// Contract
// - Select clear: limits come only from charge and discharge registers.
// - Select set (reset value): apply lower of pin limit and register limit.
// - Discharge regulation only while enable bit is 1; resets to 0.
// - First insertion after reset without a fault uses 150 ms rising deglitch regardless of select.
// - Later insertions take the deglitch time from the select bit.
// - Select bit 0 means 150 ms, 1 means 1.3 s; resets to 1.
// - Detect falling below threshold by fault forces 1.3 s deglitch.
// - Adapter present bit is read-only and mirrors the adapter-ok output.
`timescale 1ns/1ps
module charger_option_registers
	import charger_option_pkg::*;
#(
	parameter int SHORT_CYC = DEG_SHORT_CYC,
	parameter int LONG_CYC  = DEG_LONG_CYC
)(
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	input  wire logic [7:0]       reg_addr,
	input  wire logic [15:0]      reg_wdata,
	output logic      [15:0]      reg_rdata,
	input  wire logic             adapter_detect_ok,
	input  wire logic             adapter_detect_fault,
	input  wire logic [LIM_W-1:0] charge_limit_reg,
	input  wire logic [LIM_W-1:0] discharge_limit_reg,
	input  wire logic [LIM_W-1:0] current_limit_pin,
	output logic      [LIM_W-1:0] charge_limit_eff,
	output logic      [LIM_W-1:0] discharge_limit_eff,
	output logic                  discharge_regulation_on,
	output logic                  adapter_ok_output
);
	typedef enum logic [1:0] {ST_ABSENT, ST_DEGLITCH, ST_PRESENT} ok_state_t;

	logic        ext_limit_pin_select_r;
	logic        discharge_regulation_enable_r;
	logic        adapter_ok_deglitch_select_r;
	logic        det_s1_r, det_s2_r, flt_s1_r, flt_s2_r;
	logic        first_done_r;
	logic        fault_seen_r;
	logic [31:0] deg_cnt_r;
	logic [31:0] deg_target_r;
	ok_state_t   state_r;
	ok_state_t   state_nxt;
	logic        det_lost;
	logic        deg_done;
	logic        promote;
	logic        arm;
	logic [LIM_W-1:0] charge_limit_nxt;
	logic [LIM_W-1:0] discharge_limit_nxt;

	function automatic logic [LIM_W-1:0] lower_of(input logic [LIM_W-1:0] a,
		input logic [LIM_W-1:0] b);
		lower_of = (a < b) ? a : b;
	endfunction

	function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
		addr_hit = (addr == ofs);
	endfunction

	function automatic logic [31:0] pick_target(input logic fault, input logic first_done,
		input logic sel);
		if (fault)
			pick_target = 32'(LONG_CYC);
		else if (!first_done)
			pick_target = 32'(SHORT_CYC);
		else if (sel)
			pick_target = 32'(LONG_CYC);
		else
			pick_target = 32'(SHORT_CYC);
	endfunction

	// Pin inputs are asynchronous to clk
	always_ff @(posedge clk) begin
		if (!nrst) begin
			det_s1_r <= 1'b0;
			det_s2_r <= 1'b0;
			flt_s1_r <= 1'b0;
			flt_s2_r <= 1'b0;
		end else begin
			det_s1_r <= adapter_detect_ok;
			det_s2_r <= det_s1_r;
			flt_s1_r <= adapter_detect_fault;
			flt_s2_r <= flt_s1_r;
		end
	end

	// Only writable bits are stored; reserved bits never latch
	always_ff @(posedge clk) begin
		if (!nrst)
			ext_limit_pin_select_r <= RST_EXT_LIMIT;
		else if (reg_wr && addr_hit(reg_addr, OFS_OPTION_TWO))
			ext_limit_pin_select_r <= reg_wdata[POS_EXT_LIMIT];
	end

	always_ff @(posedge clk) begin
		if (!nrst)
			discharge_regulation_enable_r <= RST_DCHG_REG;
		else if (reg_wr && addr_hit(reg_addr, OFS_OPTION_THREE))
			discharge_regulation_enable_r <= reg_wdata[POS_DCHG_REG];
	end

	always_ff @(posedge clk) begin
		if (!nrst)
			adapter_ok_deglitch_select_r <= RST_DEG_SEL;
		else if (reg_wr && addr_hit(reg_addr, OFS_OPTION_THREE))
			adapter_ok_deglitch_select_r <= reg_wdata[POS_DEG_SEL];
	end

	always_comb begin
		reg_rdata = 16'h0000;
		if (reg_rd && addr_hit(reg_addr, OFS_OPTION_TWO)) begin
			reg_rdata = OPT2_FIXED;
			reg_rdata[POS_EXT_LIMIT] = ext_limit_pin_select_r;
		end else if (reg_rd && addr_hit(reg_addr, OFS_OPTION_THREE)) begin
			reg_rdata[POS_DCHG_REG] = discharge_regulation_enable_r;
			reg_rdata[POS_DEG_SEL]  = adapter_ok_deglitch_select_r;
			reg_rdata[POS_PRESENT]  = adapter_ok_output;
		end
	end

	always_comb begin
		if (ext_limit_pin_select_r) begin
			charge_limit_nxt    = lower_of(charge_limit_reg, current_limit_pin);
			discharge_limit_nxt = lower_of(discharge_limit_reg, current_limit_pin);
		end else begin
			charge_limit_nxt    = charge_limit_reg;
			discharge_limit_nxt = discharge_limit_reg;
		end
	end

	// Limit outputs registered so downstream DACs see stable codes
	always_ff @(posedge clk) begin
		if (!nrst) begin
			charge_limit_eff    <= 16'h0000;
			discharge_limit_eff <= 16'h0000;
		end else begin
			charge_limit_eff    <= charge_limit_nxt;
			discharge_limit_eff <= discharge_limit_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst)
			discharge_regulation_on <= 1'b0;
		else
			discharge_regulation_on <= discharge_regulation_enable_r;
	end

	// Fault memory holds until the next deglitch picks its time
	always_ff @(posedge clk) begin
		if (!nrst)
			fault_seen_r <= 1'b0;
		else if (flt_s2_r)
			fault_seen_r <= 1'b1;
		else if (state_r == ST_ABSENT && det_s2_r)
			fault_seen_r <= 1'b0;
	end

	// Adapter-ok rising-edge deglitch; falling edge is immediate
	assign det_lost = !det_s2_r || flt_s2_r;
	assign deg_done = (deg_cnt_r + 32'h0000_0001) >= deg_target_r;
	assign promote  = (state_r == ST_DEGLITCH) && !det_lost && deg_done;
	assign arm      = (state_r == ST_ABSENT) && det_s2_r;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_ABSENT: begin
				if (det_s2_r)
					state_nxt = ST_DEGLITCH;
			end
			ST_DEGLITCH: begin
				if (det_lost)
					state_nxt = ST_ABSENT;
				else if (deg_done)
					state_nxt = ST_PRESENT;
			end
			ST_PRESENT: begin
				if (det_lost)
					state_nxt = ST_ABSENT;
			end
			default: state_nxt = ST_ABSENT;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst)
			state_r <= ST_ABSENT;
		else
			state_r <= state_nxt;
	end

	// Counter parks one below the target so a long hold never wraps
	always_ff @(posedge clk) begin
		if (!nrst)
			deg_cnt_r <= 32'h0000_0000;
		else if (state_r == ST_ABSENT)
			deg_cnt_r <= 32'h0000_0000;
		else if (state_r == ST_DEGLITCH && !det_lost && !deg_done)
			deg_cnt_r <= deg_cnt_r + 32'h0000_0001;
	end

	// Target latched on arming, so a select write mid-deglitch waits for the next plug
	always_ff @(posedge clk) begin
		if (!nrst)
			deg_target_r <= 32'h0000_0000;
		else if (arm)
			deg_target_r <= pick_target(fault_seen_r || flt_s2_r, first_done_r,
				adapter_ok_deglitch_select_r);
	end

	always_ff @(posedge clk) begin
		if (!nrst)
			first_done_r <= 1'b0;
		else if (promote)
			first_done_r <= 1'b1;
	end

	always_ff @(posedge clk) begin
		if (!nrst)
			adapter_ok_output <= 1'b0;
		else
			adapter_ok_output <= (state_nxt == ST_PRESENT);
	end
endmodule

// ### design/charger_option_pkg.sv
// Constants for the charger option register block
package charger_option_pkg;
	localparam logic [7:0]  OFS_OPTION_THREE = 8'h37;
	localparam logic [7:0]  OFS_OPTION_TWO   = 8'h38;
	// Option two fixed read pattern: [9:8]=3, [2]=1, others zero
	localparam logic [15:0] OPT2_FIXED       = 16'h0304;
	localparam int          POS_EXT_LIMIT    = 7;
	localparam int          POS_DCHG_REG     = 15;
	localparam int          POS_DEG_SEL      = 12;
	localparam int          POS_PRESENT      = 11;
	localparam logic        RST_EXT_LIMIT    = 1'b1;
	localparam logic        RST_DCHG_REG     = 1'b0;
	localparam logic        RST_DEG_SEL      = 1'b1;
	localparam int          CLK_HZ           = 40000000;
	localparam int          DEG_SHORT_MS     = 150;
	localparam int          DEG_LONG_MS      = 1300;
	localparam int          DEG_SHORT_CYC    = DEG_SHORT_MS * (CLK_HZ / 1000);
	localparam int          DEG_LONG_CYC     = DEG_LONG_MS * (CLK_HZ / 1000);
	localparam int          LIM_W            = 16;
endpackage

// ### tb/charger_option_registers_properties.sv
// Port-level checks for the charger option registers
`timescale 1ns/1ps
module charger_option_registers_properties
	import charger_option_pkg::*;
#(
	parameter int SHORT_CYC = DEG_SHORT_CYC,
	parameter int LONG_CYC  = DEG_LONG_CYC
)(
	input wire logic clk, nrst, reg_wr, reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata, reg_rdata,
	input wire logic adapter_detect_ok, adapter_detect_fault,
	input wire logic [LIM_W-1:0] charge_limit_reg, discharge_limit_reg, current_limit_pin,
	input wire logic [LIM_W-1:0] charge_limit_eff, discharge_limit_eff,
	input wire logic discharge_regulation_on, adapter_ok_output
);
	int hi_cnt;
	wire rd2 = reg_rd && !reg_wr && reg_addr == OFS_OPTION_TWO;
	wire rd3 = reg_rd && reg_addr == OFS_OPTION_THREE;
	// Lower bound only: sync delay makes the exact rise edge fuzzy
	always_ff @(posedge clk) begin
		if (!nrst || !adapter_detect_ok || adapter_detect_fault)
			hi_cnt <= 0;
		else
			hi_cnt <= hi_cnt + 1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	a_opt2_fixed: assert property (rd2 |-> (reg_rdata & 16'hff7f) == OPT2_FIXED)
		else $error("option two fixed bits wrong");
	a_opt3_reserved: assert property (rd3 |-> reg_rdata[14:13] == 0 && reg_rdata[10:0] == 0)
		else $error("option three reserved bits not zero");
	a_present_mirror: assert property (rd3 |-> reg_rdata[11] == adapter_ok_output)
		else $error("present flag differs from adapter ok");
	a_dchg_follow: assert property (reg_wr && reg_addr == OFS_OPTION_THREE
		|-> ##2 discharge_regulation_on == $past(reg_wdata[15], 2)) else $error("enable not applied");
	a_limit_lower: assert property (rd2 && reg_rdata[7] |=> charge_limit_eff ==
		$past(current_limit_pin < charge_limit_reg ? current_limit_pin : charge_limit_reg))
		else $error("charge limit not the lower value");
	a_limit_regonly: assert property (rd2 && !reg_rdata[7] |=>
		discharge_limit_eff == $past(discharge_limit_reg)) else $error("pin used while deselected");
	a_ok_absent: assert property (!adapter_detect_ok [*4] |-> !adapter_ok_output)
		else $error("adapter ok high while absent");
	a_short_floor: assert property ($rose(adapter_ok_output) |-> hi_cnt >= SHORT_CYC - 4)
		else $error("adapter ok rose too early");
	c_select_read: cover property (rd2 && reg_rdata[7]);
	c_ok_rise: cover property ($rose(adapter_ok_output));
	c_opt3_write: cover property (reg_wr && reg_addr == OFS_OPTION_THREE);
endmodule
bind charger_option_registers charger_option_registers_properties
	#(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) props_u (.*);

// ### tb/charger_option_registers_tb.sv
// Self-checking bench for the charger option registers
`timescale 1ns/1ps
module charger_option_registers_tb;
	import charger_option_pkg::*;
	localparam int SC = 20;
	localparam int LC = 60;
	logic clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, det = 0, flt = 0, don, aok;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000, cl = 16'h0064, dl = 16'h0040, pin = 16'h0032;
	logic [15:0] reg_rdata, ce, de;
	int n_mismatch = 0, check_count = 0;
	always #12.5 clk = ~clk;
	charger_option_registers #(.SHORT_CYC(SC), .LONG_CYC(LC)) dut_u (.clk(clk), .nrst(nrst),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .adapter_detect_ok(det), .adapter_detect_fault(flt),
		.charge_limit_reg(cl), .discharge_limit_reg(dl), .current_limit_pin(pin),
		.charge_limit_eff(ce), .discharge_limit_eff(de), .discharge_regulation_on(don),
		.adapter_ok_output(aok));
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		reg_wr = 1;
		reg_addr = a;
		reg_wdata = d;
		step(1);
		reg_wr = 0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		reg_rd = 1;
		reg_addr = a;
		#1 chk("reg_rdata", reg_rdata, e);
		step(1);
		reg_rd = 0;
	endtask
	// Plug, check at first mark, check present later, unplug
	task automatic plug(input int w, input logic e, input int w2);
		det = 1;
		step(w);
		chk("adapter_ok_output", {15'h0000, aok}, {15'h0000, e});
		step(w2);
		chk("adapter_ok_output", {15'h0000, aok}, 16'h0001);
		det = 0;
		step(6);
		chk("adapter_ok_output", {15'h0000, aok}, 16'h0000);
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		step(3000);
		n_mismatch++;
		tally_and_finish;
	end
	initial begin
		step(20);
		nrst = 1;
		rd(OFS_OPTION_TWO, OPT2_FIXED | 16'h0080);
		rd(OFS_OPTION_THREE, 16'h1000);
		chk("charge_limit_eff", ce, 16'h0032);
		chk("discharge_limit_eff", de, 16'h0032);
		plug(SC + 6, 1'b1, 1);
		plug(SC + 6, 1'b0, LC - SC);
		wr(OFS_OPTION_TWO, 16'hff7f);
		rd(OFS_OPTION_TWO, OPT2_FIXED);
		chk("charge_limit_eff", ce, 16'h0064);
		chk("discharge_limit_eff", de, 16'h0040);
		wr(OFS_OPTION_THREE, 16'h6fff);
		rd(OFS_OPTION_THREE, 16'h0000);
		wr(OFS_OPTION_THREE, 16'h8000);
		rd(OFS_OPTION_THREE, 16'h8000);
		chk("discharge_regulation_on", {15'h0000, don}, 16'h0001);
		plug(SC + 6, 1'b1, 1);
		flt = 1;
		step(4);
		flt = 0;
		plug(SC + 6, 1'b0, LC - SC);
		tally_and_finish;
	end
endmodule
